//--- design/pcxb_regs.svh
// Register offsets, field positions, reset values and sizes of the pin crossbar
`ifndef PCXB_REGS_SVH
`define PCXB_REGS_SVH

`define PCXB_NPIN        25
`define PCXB_NSIG        14
`define PCXB_PIN_MASK    32'h01FFFFFF

`define PCXB_SEL0_ADDR   8'hE1
`define PCXB_SEL2_ADDR   8'hC7
`define PCXB_LATCH_BASE  8'h80
`define PCXB_MDOUT_BASE  8'hA4
`define PCXB_SKIP_BASE   8'hD4
`define PCXB_MDIN_BASE   8'hF4

`define PCXB_SEL0_RESET  8'h00
`define PCXB_SEL0_WMASK  8'hFD
`define PCXB_SEL2_RESET  8'h00
`define PCXB_SEL2_WMASK  8'hC1
`define PCXB_MDIN_RESET  32'h01FFFFFF
`define PCXB_MDOUT_RESET 32'h00000000
`define PCXB_SKIP_RESET  32'h00000000
`define PCXB_LATCH_RESET 32'h01FFFFFF

`define PCXB_UART_BIT    0
`define PCXB_SPI_BIT     2
`define PCXB_SMB_BIT     3
`define PCXB_CP0_BIT     4
`define PCXB_CP0A_BIT    5
`define PCXB_CP1_BIT     6
`define PCXB_CP1A_BIT    7
`define PCXB_LIN_BIT     0
`define PCXB_XON_BIT     6
`define PCXB_WPOFF_BIT   7

`define PCXB_UART_TX_PIN 4
`define PCXB_UART_RX_PIN 5

`endif

//--- design/pcxb_pkg.sv
// Types shared by the pin crossbar modules
package pcxb_pkg;

    // Peripheral signals, numbered in default priority order
    typedef enum logic [3:0] {
        SIG_UART_TX  = 4'h0,
        SIG_UART_RX  = 4'h1,
        SIG_SPI_SCK  = 4'h2,
        SIG_SPI_MISO = 4'h3,
        SIG_SPI_MOSI = 4'h4,
        SIG_SPI_NSS  = 4'h5,
        SIG_SMB_SDA  = 4'h6,
        SIG_SMB_SCL  = 4'h7,
        SIG_CMP0     = 4'h8,
        SIG_CMP0A    = 4'h9,
        SIG_CMP1     = 4'hA,
        SIG_CMP1A    = 4'hB,
        SIG_LIN_TX   = 4'hC,
        SIG_LIN_RX   = 4'hD
    } pcxb_sig_t;

    typedef logic [3:0] pcxb_sig_idx_t;

endpackage : pcxb_pkg

//--- design/pcxb_alloc.sv
// Priority allocator: gives each requested signal except the UART pair the lowest free pin
`timescale 1ns/100ps
`include "pcxb_regs.svh"

module pcxb_alloc (
    // Requests and skip mask
    input  wire logic [`PCXB_NSIG-1:0]            req,
    input  wire logic [`PCXB_NPIN-1:0]            skip,
    // Result per pin
    output logic      [`PCXB_NPIN-1:0]            assigned,
    output logic      [`PCXB_NPIN-1:0][3:0]       sig_of
);

    // Service order; may be reordered for another priority scheme
    localparam pcxb_pkg::pcxb_sig_t ORDER [`PCXB_NSIG] = '{
        pcxb_pkg::SIG_UART_TX, pcxb_pkg::SIG_UART_RX, pcxb_pkg::SIG_SPI_SCK,
        pcxb_pkg::SIG_SPI_MISO, pcxb_pkg::SIG_SPI_MOSI, pcxb_pkg::SIG_SPI_NSS,
        pcxb_pkg::SIG_SMB_SDA, pcxb_pkg::SIG_SMB_SCL, pcxb_pkg::SIG_CMP0,
        pcxb_pkg::SIG_CMP0A, pcxb_pkg::SIG_CMP1, pcxb_pkg::SIG_CMP1A,
        pcxb_pkg::SIG_LIN_TX, pcxb_pkg::SIG_LIN_RX};

    logic [`PCXB_NPIN-1:0] taken;
    logic                  found;

    always_comb begin
        taken    = skip;
        assigned = '0;
        sig_of   = '0;
        found    = 1'b0;
        // Fixed pins for the primary UART
        if (req[pcxb_pkg::SIG_UART_TX]) begin
            taken[`PCXB_UART_TX_PIN]    = 1'b1;
            taken[`PCXB_UART_RX_PIN]    = 1'b1;
            assigned[`PCXB_UART_TX_PIN] = 1'b1;
            assigned[`PCXB_UART_RX_PIN] = 1'b1;
            sig_of[`PCXB_UART_TX_PIN]   = pcxb_pkg::SIG_UART_TX;
            sig_of[`PCXB_UART_RX_PIN]   = pcxb_pkg::SIG_UART_RX;
        end
        for (int k = 0; k < `PCXB_NSIG; k++) begin
            found = 1'b0;
            if (req[ORDER[k]] && ORDER[k] != pcxb_pkg::SIG_UART_TX
                    && ORDER[k] != pcxb_pkg::SIG_UART_RX) begin
                for (int p = 0; p < `PCXB_NPIN; p++) begin
                    if (!found && !taken[p]) begin
                        found       = 1'b1;
                        taken[p]    = 1'b1;
                        assigned[p] = 1'b1;
                        sig_of[p]   = ORDER[k];
                    end
                end
            end
        end
    end

endmodule : pcxb_alloc

//--- design/pcxb_top.sv
// Port pin crossbar: pin modes, skip masks, routing registers and pad control
//
// Notes on behaviour
// - Event capture on all digital pins only
// - Lowest free pin, fixed priority from UART
// - UART transmit P0.4, receive P0.5 always
// - Assigned pins passed over for later signals
// - Skipped pins treated as already assigned
// - SMBus, UART, LIN claim pin pairs
// - Unclaimed pins stay ordinary port pins
// - SPI takes three or four pins
// - Crossbar off keeps pins as inputs
// - Output drivers off while crossbar off
// - Input-mode bit: 1 digital, 0 analog
// - Analog pin: pull-up, driver, receiver off
// - Output-mode bit; SMBus pins always open-drain
// - Pull-up on open-drain pins unless disabled
// - Pull-up off while driving low
// - Route bits 7..4 enable comparator outputs
// - Route bits 3,2,0 enable SMBus, SPI, UART
// - Analog pins read back zero
// - Reset leaves pins high-impedance with pull-ups
`timescale 1ns/100ps
`include "pcxb_regs.svh"

module pcxb_top (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // Peripheral side
    input  wire logic [`PCXB_NSIG-1:0]   periph_out,
    input  wire logic [`PCXB_NSIG-1:0]   periph_oe,
    input  wire logic [1:0]              spi_slave_select_mode,
    output logic      [`PCXB_NSIG-1:0]   periph_in,
    output logic      [`PCXB_NPIN-1:0]   pin_event,
    // Pad side
    input  wire logic [`PCXB_NPIN-1:0]   pin_in,
    output logic      [`PCXB_NPIN-1:0]   pin_out,
    output logic      [`PCXB_NPIN-1:0]   pin_oe_n,
    output logic      [`PCXB_NPIN-1:0]   pin_pullup,
    output logic      [`PCXB_NPIN-1:0]   pin_in_en
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] get_byte(input logic [31:0] v, input logic [1:0] n);
        get_byte = v[{n, 3'b000} +: 8];
    endfunction : get_byte

    function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [1:0] n,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = v;
        r[{n, 3'b000} +: 8] = b;
        put_byte = r & `PCXB_PIN_MASK;
    endfunction : put_byte

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]  peripheral_route_select_0;
    logic [7:0]  peripheral_route_select_2;
    logic [31:0] pin_input_mode;
    logic [31:0] pin_output_mode;
    logic [31:0] pin_skip_mask;
    logic [31:0] port_latch;
    logic [7:0]  next_route_0;
    logic [7:0]  next_route_2;
    logic [31:0] next_input_mode;
    logic [31:0] next_output_mode;
    logic [31:0] next_skip_mask;
    logic [31:0] next_latch;
    logic [7:0]  next_rdata;
    logic [31:0] pad_read;
    logic [1:0]  byte_sel;

    assign byte_sel = reg_addr[1:0];
    assign pad_read = 32'(pin_in & pin_input_mode[`PCXB_NPIN-1:0]);

    always_comb begin
        next_route_0     = peripheral_route_select_0;
        next_route_2     = peripheral_route_select_2;
        next_input_mode  = pin_input_mode;
        next_output_mode = pin_output_mode;
        next_skip_mask   = pin_skip_mask;
        next_latch       = port_latch;
        next_rdata       = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `PCXB_SEL0_ADDR) begin
                next_route_0 = reg_wdata & `PCXB_SEL0_WMASK;
            end
            if (reg_addr == `PCXB_SEL2_ADDR) begin
                next_route_2 = reg_wdata & `PCXB_SEL2_WMASK;
            end
            unique case ({2'h0, reg_addr[7:2]})
                `PCXB_MDIN_BASE >> 2:  next_input_mode  = put_byte(pin_input_mode,
                                                                   byte_sel, reg_wdata);
                `PCXB_MDOUT_BASE >> 2: next_output_mode = put_byte(pin_output_mode,
                                                                   byte_sel, reg_wdata);
                `PCXB_SKIP_BASE >> 2:  next_skip_mask   = put_byte(pin_skip_mask,
                                                                   byte_sel, reg_wdata);
                `PCXB_LATCH_BASE >> 2: next_latch       = put_byte(port_latch,
                                                                   byte_sel, reg_wdata);
                default:               next_latch       = port_latch;
            endcase
        end
        if (reg_rd) begin
            if (reg_addr == `PCXB_SEL0_ADDR) begin
                next_rdata = peripheral_route_select_0;
            end
            if (reg_addr == `PCXB_SEL2_ADDR) begin
                next_rdata = peripheral_route_select_2;
            end
            unique case ({2'h0, reg_addr[7:2]})
                `PCXB_MDIN_BASE >> 2:  next_rdata = get_byte(pin_input_mode, byte_sel);
                `PCXB_MDOUT_BASE >> 2: next_rdata = get_byte(pin_output_mode, byte_sel);
                `PCXB_SKIP_BASE >> 2:  next_rdata = get_byte(pin_skip_mask, byte_sel);
                `PCXB_LATCH_BASE >> 2: next_rdata = get_byte(pad_read, byte_sel);
                default:               next_rdata = next_rdata;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_route_select_0 <= `PCXB_SEL0_RESET;
            peripheral_route_select_2 <= `PCXB_SEL2_RESET;
            pin_input_mode            <= `PCXB_MDIN_RESET;
            pin_output_mode           <= `PCXB_MDOUT_RESET;
            pin_skip_mask             <= `PCXB_SKIP_RESET;
            port_latch                <= `PCXB_LATCH_RESET;
            reg_rdata                 <= 8'h00;
        end else begin
            peripheral_route_select_0 <= next_route_0;
            peripheral_route_select_2 <= next_route_2;
            pin_input_mode            <= next_input_mode;
            pin_output_mode           <= next_output_mode;
            pin_skip_mask             <= next_skip_mask;
            port_latch                <= next_latch;
            reg_rdata                 <= next_rdata;
        end
    end

    // ************************************************************
    // Allocation
    // ************************************************************
    logic                            crossbar_on;
    logic                            weak_pullup_off;
    logic [`PCXB_NSIG-1:0]           req;
    logic [`PCXB_NPIN-1:0]           alloc_assigned;
    logic [`PCXB_NPIN-1:0][3:0]      alloc_sig;

    assign crossbar_on     = peripheral_route_select_2[`PCXB_XON_BIT];
    assign weak_pullup_off = peripheral_route_select_2[`PCXB_WPOFF_BIT];

    always_comb begin
        req = '0;
        req[pcxb_pkg::SIG_UART_TX]  = peripheral_route_select_0[`PCXB_UART_BIT];
        req[pcxb_pkg::SIG_UART_RX]  = peripheral_route_select_0[`PCXB_UART_BIT];
        req[pcxb_pkg::SIG_SPI_SCK]  = peripheral_route_select_0[`PCXB_SPI_BIT];
        req[pcxb_pkg::SIG_SPI_MISO] = peripheral_route_select_0[`PCXB_SPI_BIT];
        req[pcxb_pkg::SIG_SPI_MOSI] = peripheral_route_select_0[`PCXB_SPI_BIT];
        req[pcxb_pkg::SIG_SPI_NSS]  = peripheral_route_select_0[`PCXB_SPI_BIT]
                                      & (spi_slave_select_mode != 2'h0);
        req[pcxb_pkg::SIG_SMB_SDA]  = peripheral_route_select_0[`PCXB_SMB_BIT];
        req[pcxb_pkg::SIG_SMB_SCL]  = peripheral_route_select_0[`PCXB_SMB_BIT];
        req[pcxb_pkg::SIG_CMP0]     = peripheral_route_select_0[`PCXB_CP0_BIT];
        req[pcxb_pkg::SIG_CMP0A]    = peripheral_route_select_0[`PCXB_CP0A_BIT];
        req[pcxb_pkg::SIG_CMP1]     = peripheral_route_select_0[`PCXB_CP1_BIT];
        req[pcxb_pkg::SIG_CMP1A]    = peripheral_route_select_0[`PCXB_CP1A_BIT];
        req[pcxb_pkg::SIG_LIN_TX]   = peripheral_route_select_2[`PCXB_LIN_BIT];
        req[pcxb_pkg::SIG_LIN_RX]   = peripheral_route_select_2[`PCXB_LIN_BIT];
    end

    pcxb_alloc u_alloc (
        .req      (req),
        .skip     (pin_skip_mask[`PCXB_NPIN-1:0]),
        .assigned (alloc_assigned),
        .sig_of   (alloc_sig)
    );

    // ************************************************************
    // Pad control
    // ************************************************************
    logic [`PCXB_NPIN-1:0] next_pin_out;
    logic [`PCXB_NPIN-1:0] next_pin_oe_n;
    logic [`PCXB_NPIN-1:0] next_pin_pullup;
    logic [`PCXB_NPIN-1:0] next_pin_in_en;
    logic [`PCXB_NPIN-1:0] next_pin_event;
    logic [`PCXB_NSIG-1:0] next_periph_in;

    always_comb begin
        logic dig;
        logic routed;
        logic val;
        logic drv;
        logic od;
        logic low;
        logic high;
        dig            = 1'b0;
        routed         = 1'b0;
        val            = 1'b0;
        drv            = 1'b0;
        od             = 1'b0;
        low            = 1'b0;
        high           = 1'b0;
        next_periph_in = '0;
        for (int i = 0; i < `PCXB_NPIN; i++) begin
            dig    = pin_input_mode[i];
            routed = crossbar_on & alloc_assigned[i];
            val    = routed ? periph_out[alloc_sig[i]] : port_latch[i];
            drv    = crossbar_on & dig & (routed ? periph_oe[alloc_sig[i]] : 1'b1);
            od     = ~pin_output_mode[i] | (routed & ((alloc_sig[i] == pcxb_pkg::SIG_SMB_SDA)
                     | (alloc_sig[i] == pcxb_pkg::SIG_SMB_SCL)));
            low    = drv & ~val;
            high   = drv & val & ~od;
            next_pin_out[i]    = high;
            next_pin_oe_n[i]   = ~(low | high);
            next_pin_pullup[i] = crossbar_on ? (dig & ~weak_pullup_off & od & ~low)
                                             : (dig & ~weak_pullup_off);
            next_pin_in_en[i]  = dig;
            next_pin_event[i]  = pin_in[i] & dig;
            if (routed) begin
                next_periph_in[alloc_sig[i]] = pin_in[i] & dig;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out    <= '0;
            pin_oe_n   <= '1;
            pin_pullup <= '1;
            pin_in_en  <= '1;
            pin_event  <= '0;
            periph_in  <= '0;
        end else begin
            pin_out    <= next_pin_out;
            pin_oe_n   <= next_pin_oe_n;
            pin_pullup <= next_pin_pullup;
            pin_in_en  <= next_pin_in_en;
            pin_event  <= next_pin_event;
            periph_in  <= next_periph_in;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_off_no_drive: assert property (!crossbar_on |=> &pin_oe_n)
        else $error("pin driven while crossbar off");
    a_analog_quiet: assert property (1'b1 |=> ((~$past(pin_input_mode[`PCXB_NPIN-1:0]))
        & (pin_pullup | ~pin_oe_n | pin_in_en | pin_event)) == '0)
        else $error("analog pin not isolated");
    a_analog_read: assert property (reg_rd && reg_addr == `PCXB_LATCH_BASE
        |=> (reg_rdata & ~$past(pin_input_mode[7:0])) == 8'h00)
        else $error("analog pin read nonzero");
    a_uart_fixed: assert property (peripheral_route_select_0[`PCXB_UART_BIT]
        |-> alloc_assigned[`PCXB_UART_TX_PIN] && alloc_sig[`PCXB_UART_TX_PIN] == 4'h0
        && alloc_sig[`PCXB_UART_RX_PIN] == 4'h1)
        else $error("uart not on fixed pins");
    a_skip_free: assert property ((pin_skip_mask[`PCXB_NPIN-1:0] & alloc_assigned
        & ~(25'h1 << `PCXB_UART_TX_PIN) & ~(25'h1 << `PCXB_UART_RX_PIN)) == '0)
        else $error("skipped pin assigned");
    a_smbus_od: assert property (crossbar_on && alloc_assigned[0]
        && alloc_sig[0] == pcxb_pkg::SIG_SMB_SDA |=> !pin_out[0])
        else $error("smbus pin driven high");
    a_low_no_pull: assert property ((~pin_oe_n & ~pin_out & pin_pullup) == '0)
        else $error("pull-up on while driving low");

    // Any pin carrying slave select, seen from the allocator result
    logic nss_placed;

    always_comb begin
        nss_placed = 1'b0;
        for (int i = 0; i < `PCXB_NPIN; i++) begin
            nss_placed = nss_placed
                | (alloc_assigned[i] & (alloc_sig[i] == pcxb_pkg::SIG_SPI_NSS));
        end
    end

    a_spi_three: assert property (peripheral_route_select_0[`PCXB_SPI_BIT]
        && spi_slave_select_mode == 2'h0 |-> !nss_placed)
        else $error("slave select routed in three-wire mode");
    a_sel0_rsvd: assert property (1'b1 |=> !peripheral_route_select_0[1])
        else $error("reserved route bit set");
    a_od_pullup: assert property (crossbar_on && !weak_pullup_off && pin_input_mode[1]
        && !pin_output_mode[1] && !alloc_assigned[1] && port_latch[1]
        |=> pin_pullup[1] && pin_oe_n[1])
        else $error("open-drain pin lacks pull-up");
    a_off_no_route: assert property (!crossbar_on |=> periph_in == '0)
        else $error("peripheral input routed while crossbar off");
    a_rx_mode: assert property (1'b1 |=>
        pin_in_en == $past(pin_input_mode[`PCXB_NPIN-1:0]))
        else $error("receiver enable does not follow input mode");

    c_xbar_on:  cover property (!crossbar_on ##1 crossbar_on);
    c_uart:     cover property (crossbar_on && peripheral_route_select_0[`PCXB_UART_BIT]);
    c_spi_four: cover property (crossbar_on && req[pcxb_pkg::SIG_SPI_NSS]);
    c_smbus:    cover property (crossbar_on && req[pcxb_pkg::SIG_SMB_SDA]);
    c_xbar_off: cover property (crossbar_on ##1 !crossbar_on);

endmodule : pcxb_top

//--- verification/pcxb_pad_model.sv
// Board-side model of the circuitry hanging on the crossbar pins
`timescale 1ns/100ps
`include "pcxb_regs.svh"

module pcxb_pad_model (
    // Clock
    input  wire logic                  core_clk,
    // Device pad controls
    input  wire logic [`PCXB_NPIN-1:0] pin_out,
    input  wire logic [`PCXB_NPIN-1:0] pin_oe_n,
    input  wire logic [`PCXB_NPIN-1:0] pin_pullup,
    // External resistive sources
    input  wire logic [`PCXB_NPIN-1:0] ext_en,
    input  wire logic [`PCXB_NPIN-1:0] ext_val,
    // Pad levels seen by the device
    output logic      [`PCXB_NPIN-1:0] pin_in
);
    logic [`PCXB_NPIN-1:0] float_q = '0;

    // Undriven, unpulled pads wander every cycle
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Device driver beats the external source, which beats the pull-up
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & (pin_pullup | float_q));
endmodule : pcxb_pad_model

//--- verification/tb_top.sv
// Self-checking bench for the pin crossbar with random configurations
`timescale 1ns/100ps
`include "pcxb_regs.svh"

module tb_top;
    localparam int NP = `PCXB_NPIN;
    logic          core_clk, rst_n, reg_wr, reg_rd;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata;
    logic [13:0]   periph_out, periph_oe, periph_in;
    logic [1:0]    spi_slave_select_mode;
    logic [NP-1:0] pin_event, pin_in, pin_out, pin_oe_n, pin_pullup, pin_in_en;
    logic [NP-1:0] ext_en, ext_val, lt;
    logic [31:0]   seed;
    int            miscompares, cmp_count, cycles;

    pcxb_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .spi_slave_select_mode(spi_slave_select_mode), .periph_in(periph_in),
        .pin_event(pin_event), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .pin_in_en(pin_in_en));

    pcxb_pad_model u_pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ***********************************
    // Helpers
    // ***********************************
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic write32(input logic [7:0] base, input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            reg_write(base + 8'(i), v[8*i+:8]);
        end
    endtask : write32

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(32'(reg_rdata), 32'(exp), "register read");
    endtask : rd_chk

    // Lowest free pin per requested signal, UART fixed
    function automatic void plan_pins(input logic [7:0] r0, input logic lin,
        input logic [1:0] md, input logic [NP-1:0] skip, output int sig_at[NP]);
        logic [13:0]   req;
        logic [NP-1:0] used;
        req = {lin, lin, r0[7:4], r0[3], r0[3], md != 2'h0 && r0[2], {3{r0[2]}}, 2'b00};
        used = skip;
        foreach (sig_at[p]) sig_at[p] = -1;
        if (r0[0]) begin
            sig_at[4] = 0;
            sig_at[5] = 1;
            used[5:4] = 2'b11;
        end
        for (int s = 2; s < 14; s++) begin
            for (int p = 0; p < NP && req[s]; p++) begin
                if (!used[p]) begin
                    sig_at[p] = s;
                    used[p] = 1'b1;
                    break;
                end
            end
        end
    endfunction : plan_pins

    task automatic check_pins(input logic [7:0] r0, input logic [7:0] r2, input logic [1:0] md,
        input logic [NP-1:0] skip, input logic [NP-1:0] mdin, input logic [NP-1:0] mdout);
        int            sig_at[NP];
        logic [NP-1:0] e_oen, e_out, e_pu, pu_m, pad;
        logic [13:0]   e_pin;
        logic          en, val, od, drv;
        plan_pins(r0, r2[0], md, skip, sig_at);
        e_pin = '0;
        for (int p = 0; p < NP; p++) begin
            int s;
            s = sig_at[p];
            en = (s < 0) ? 1'b1 : periph_oe[s];
            val = (s < 0) ? lt[p] : periph_out[s];
            od = !mdout[p] || s == 6 || s == 7;
            drv = r2[6] && mdin[p] && en;
            e_oen[p] = !(drv && (!od || !val));
            e_out[p] = drv && !od && val;
            e_pu[p] = mdin[p] && !r2[7] && e_oen[p];
            pu_m[p] = !(r2[6] && mdin[p] && !od && !(drv && !val));
            pad[p] = !e_oen[p] ? e_out[p] : ext_val[p];
            if (s >= 0 && r2[6]) e_pin[s] = pad[p] & mdin[p];
        end
        check(32'(pin_oe_n), 32'(e_oen), "output enables");
        check(32'(pin_out), 32'(e_out), "pin drive");
        check(32'(pin_pullup & pu_m), 32'(e_pu & pu_m), "pull-ups");
        check(32'(pin_in_en), 32'(mdin), "receivers");
        check(32'(pin_event), 32'(pad & mdin), "event source");
        check(32'(periph_in), 32'(e_pin), "routed inputs");
        rd_chk(8'h80, pad[7:0] & mdin[7:0]);
    endtask : check_pins

    // ***********************************
    // Timeout and main sequence
    // ***********************************
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0]    r0, r2;
        logic [1:0]    md;
        logic [NP-1:0] sk, mi, mo;
        seed = 32'h819E;
        {miscompares, cmp_count, cycles} = '0;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {periph_out, periph_oe, spi_slave_select_mode, ext_val} = '0;
        ext_en = '1;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check(32'(pin_oe_n), 32'h01FFFFFF, "reset enables");
        check(32'(pin_pullup), 32'h01FFFFFF, "reset pull-ups");
        check(32'(pin_in_en), 32'h01FFFFFF, "reset receivers");
        rd_chk(8'hE1, 8'h00);
        rd_chk(8'hC7, 8'h00);
        rd_chk(8'hF4, 8'hFF);
        rd_chk(8'hF7, 8'h01);
        rd_chk(8'hA4, 8'h00);
        rd_chk(8'hD4, 8'h00);
        rd_chk(8'h55, 8'h00);
        @(posedge core_clk);
        #1;
        check(32'(reg_rdata), 32'h0, "read data lingers");
        reg_write(8'hE1, 8'hFF);
        rd_chk(8'hE1, 8'hFD);
        for (int it = 0; it < 40; it++) begin
            r0 = 8'(next_rand()) & 8'hFD;
            r2 = (8'(next_rand()) & 8'h81) | ((it % 4 != 3) ? 8'h40 : 8'h00);
            md = 2'(next_rand());
            mi = NP'(next_rand() | next_rand());
            mo = NP'(next_rand());
            sk = NP'(next_rand() & next_rand());
            lt = NP'(next_rand());
            if (it == 0) sk = 25'h000000F;
            if (it == 1) {sk, r0, r2} = {25'h0FFFFFF, 8'h0D, 8'h41};
            if (it == 2) {sk, r0, r2, md} = {25'h0, 8'hFD, 8'h41, 2'h3};
            reg_write(8'hC7, r2 & 8'hBF);
            write32(8'hF4, 32'(mi));
            write32(8'hA4, 32'(mo));
            write32(8'hD4, 32'(sk));
            write32(8'h80, 32'(lt));
            reg_write(8'hE1, r0);
            reg_write(8'hC7, r2);
            periph_out <= 14'(next_rand());
            periph_oe <= 14'(next_rand());
            ext_val <= NP'(next_rand());
            spi_slave_select_mode <= md;
            repeat (3) @(posedge core_clk);
            #1;
            check_pins(r0, r2, md, sk, mi, mo);
        end
        tally_and_finish();
    end
endmodule : tb_top
